// [hdl/crs_pkg.sv]
// Package for the core register set: register indices, fields, modes, bus codes.
// Assumes a single 50 MHz clock domain and an AHB-Lite bus outside.
package crs_pkg;
  localparam int CRS_CLK_MHZ = 50;
  localparam logic [3:0] CRS_IDX_SP = 4'hD;
  localparam logic [3:0] CRS_IDX_LR = 4'hE;
  localparam logic [3:0] CRS_IDX_PC = 4'hF;
  localparam int CRS_NUM_GPR = 13;
  localparam logic [31:0] CRS_SP_MASK = 32'hFFFFFFFC;
  localparam logic [31:0] CRS_PC_MASK = 32'hFFFFFFFE;
  localparam logic [31:0] CRS_ZERO = 32'h00000000;
  localparam logic [31:0] CRS_VEC_SP_ADDR = 32'h00000000;
  localparam logic [31:0] CRS_VEC_RESET_ADDR = 32'h00000004;
  localparam logic [31:0] CRS_PC_STEP = 32'h00000002;
  // Exception exit code bit that selects the thread alternate stack
  localparam int CRS_EXIT_SPSEL_BIT = 2;
  localparam int CRS_EXIT_THREAD_BIT = 3;
  localparam int CRS_CTRL_SPSEL_BIT = 1;
  localparam logic [1:0] CRS_HTRANS_IDLE = 2'h0;
  localparam logic [1:0] CRS_HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0] CRS_HSIZE_WORD = 3'h2;
  localparam logic [2:0] CRS_HBURST_SINGLE = 3'h0;
  localparam logic [3:0] CRS_HPROT_DATA = 4'h3;
  localparam int CRS_PRIO_W = 2;

  typedef enum logic [2:0] {
    CRS_ST_RESET = 3'h0,
    CRS_ST_LOAD_SP = 3'h1,
    CRS_ST_LOAD_PC = 3'h2,
    CRS_ST_RUN = 3'h3,
    CRS_ST_SAVE = 3'h4,
    CRS_ST_RESTORE = 3'h5,
    CRS_ST_HALT = 3'h6,
    CRS_ST_LOCK = 3'h7
  } crs_state_t;

  // Register port request from the execution pipeline
  typedef struct packed {
    logic wr_en;
    logic [3:0] wr_idx;
    logic [31:0] wr_data;
    logic [3:0] rd_idx;
    logic narrow;
  } crs_req_t;

  typedef struct packed {
    logic ctrl_wr;
    logic [31:0] ctrl_data;
    logic branch_link;
    logic exc_enter;
    logic exc_exit;
    logic [31:0] exit_code;
    logic pc_wr;
    logic [31:0] pc_data;
  } crs_evt_t;
endpackage : crs_pkg

// [hdl/crs_core_regs.sv]
// Architectural register set, mode and stack selection, state save, bus master pins.
// Assumes the pipeline drives requests on clk; pins reset/watchdog/debug are asynchronous.
// Summary of operation
// - Thirteen general registers plus SP, LR, PC
// - Low registers always reachable; high may be refused
// - Stack pointer writes drop bits one, zero
// - Handler uses main stack; thread configurable
// - Reset selects main stack pointer
// - Exit code moves thread onto process stack
// - Control write in thread selects process stack
// - Register 13 shows exactly one stack pointer
// - Branch with link loads return address
// - Link register holds exit code, else general
// - Program counter bit zero reads zero
// - Thread on reset, handler on exception
// - Normal execution state and debug state
// - State saved and restored automatically on interrupts
// - One interrupt source, four priority levels
// - Master drives address, write data; slave answers
// - Reset output; power-on and watchdog inputs
// - Debug_halt_flag and core_stuck_flag status outputs
// - Main stack loaded from first vector
// - Control register holds stack selection
// - Resets never clear general registers
`timescale 1ns/1ps
`default_nettype none
module crs_core_regs
  import crs_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic external_power_on_reset_n,
  input wire logic watchdog_reset_in,
  input wire logic external_debug_request,
  input wire logic debug_resume,
  input wire logic fault_in_handler,
  input wire logic irq_in,
  input wire logic [CRS_PRIO_W-1:0] irq_prio,
  input wire logic [CRS_PRIO_W-1:0] run_prio,
  input wire crs_req_t req,
  input wire crs_evt_t evt,
  output logic [31:0] rd_data,
  output logic rd_refused,
  output logic [31:0] program_counter,
  output logic handler_mode,
  output logic sp_select,
  output logic irq_take,
  output logic regs_busy,
  output logic hresetn,
  output logic watchdog_timer_reset_out_n,
  output logic debug_halt_flag,
  output logic core_stuck_flag,
  input wire logic hready,
  input wire logic hresp,
  input wire logic [31:0] hrdata,
  output logic [31:0] haddr,
  output logic [31:0] hwdata,
  output logic [1:0] htrans,
  output logic hwrite,
  output logic [2:0] hsize,
  output logic [2:0] hburst,
  output logic [3:0] hprot,
  output logic hmastlock
);
  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [2:0] pin_meta;
  logic [2:0] pin_sync;
  always_ff @(posedge clk) begin
    pin_meta <= {external_power_on_reset_n, watchdog_reset_in, external_debug_request};
    pin_sync <= pin_meta;
  end
  wire por_n_s = pin_sync[2];
  wire wdog_s = pin_sync[1];
  wire dbg_req_s = pin_sync[0];
  // Combined system reset from pin, watchdog and local reset
  wire sys_rst = !rstn || !por_n_s || wdog_s;

  // ----------------------------------------------------------------
  // Register storage
  // ----------------------------------------------------------------
  // Not reset: contents survive local, power-on and watchdog reset
  logic [31:0] gpr [0:CRS_NUM_GPR-1];
  logic [31:0] link_register;
  logic [31:0] primary_stack_pointer;
  logic [31:0] thread_alt_stack_pointer;
  logic ctrl_spsel;
  crs_state_t state;
  crs_state_t next_state;
  logic [3:0] save_cnt;
  logic irq_pending;
  // Stack chosen for the current frame, latched so the mode flip cannot split it
  logic frame_alt;
  // Bus beat tags: address phase, then data phase one accepted beat later
  localparam logic [1:0] BEAT_NONE = 2'h0;
  localparam logic [1:0] BEAT_SP = 2'h1;
  localparam logic [1:0] BEAT_PC = 2'h2;
  localparam logic [1:0] BEAT_POP = 2'h3;
  logic [1:0] a_kind;
  logic [3:0] a_idx;
  logic [1:0] d_kind;
  logic [3:0] d_idx;
  logic [31:0] push_data;

  wire bus_idle = a_kind == BEAT_NONE && d_kind == BEAT_NONE;
  wire in_thread = !handler_mode;
  // Run waits until every read beat has landed
  wire running = state == CRS_ST_RUN && bus_idle;
  wire pop_wr = hready && d_kind == BEAT_POP;
  wire sp_load = hready && d_kind == BEAT_SP;
  wire pc_load = hready && d_kind == BEAT_PC;
  // Handler always on main stack; thread follows control bit
  wire use_alt = in_thread && ctrl_spsel;
  wire [31:0] banked_stack_alias = use_alt ? thread_alt_stack_pointer
                                           : primary_stack_pointer;
  wire [31:0] wr_sp_value = req.wr_data & CRS_SP_MASK;
  // Narrow encodings reach only the low registers
  wire rd_high = req.rd_idx[3];
  wire refuse_rd = req.narrow && rd_high;
  wire refuse_wr = req.narrow && req.wr_idx[3];
  wire gpr_wr = running && req.wr_en && !refuse_wr && (req.wr_idx < CRS_IDX_SP);
  wire sp_wr = running && req.wr_en && !refuse_wr && (req.wr_idx == CRS_IDX_SP);
  wire lr_wr = running && req.wr_en && !refuse_wr && (req.wr_idx == CRS_IDX_LR);
  wire [31:0] ret_addr = program_counter + CRS_PC_STEP;
  wire [31:0] rd_mux = (req.rd_idx == CRS_IDX_SP) ? banked_stack_alias :
                       (req.rd_idx == CRS_IDX_LR) ? link_register :
                       (req.rd_idx == CRS_IDX_PC) ? program_counter :
                       gpr[req.rd_idx];
  // Higher urgency means lower number; one source only
  wire irq_wins = irq_pending && (irq_prio < run_prio || in_thread);
  wire exit_to_thread = evt.exit_code[CRS_EXIT_THREAD_BIT];
  wire exit_alt = evt.exit_code[CRS_EXIT_SPSEL_BIT];

  // ----------------------------------------------------------------
  // General registers
  // ----------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < CRS_NUM_GPR; gi++) begin : g_gpr
      always_ff @(posedge clk) begin
        if (pop_wr && d_idx == 4'(gi)) begin
          gpr[gi] <= hrdata;
        end else if (gpr_wr && req.wr_idx == 4'(gi)) begin
          gpr[gi] <= req.wr_data;
        end
      end
    end
  endgenerate

  always_ff @(posedge clk) begin
    if (running && evt.branch_link) begin
      link_register <= ret_addr;
    end else if (state == CRS_ST_SAVE && save_cnt == 4'h0) begin
      link_register <= {28'hFFFFFFF, 1'b1, frame_alt, 2'h1};
    end else if (lr_wr) begin
      link_register <= req.wr_data;
    end
  end

  // ----------------------------------------------------------------
  // Stack pointers and selection
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (sp_load) begin
      primary_stack_pointer <= hrdata & CRS_SP_MASK;
    end else if (sp_wr && !use_alt) begin
      primary_stack_pointer <= wr_sp_value;
    end else if (state == CRS_ST_SAVE && hready && !frame_alt) begin
      primary_stack_pointer <= primary_stack_pointer - 32'h4;
    end else if (state == CRS_ST_RESTORE && hready && !frame_alt) begin
      primary_stack_pointer <= primary_stack_pointer + 32'h4;
    end
  end

  always_ff @(posedge clk) begin
    if (sp_wr && use_alt) begin
      thread_alt_stack_pointer <= wr_sp_value;
    end else if (state == CRS_ST_SAVE && hready && frame_alt) begin
      thread_alt_stack_pointer <= thread_alt_stack_pointer - 32'h4;
    end else if (state == CRS_ST_RESTORE && hready && frame_alt) begin
      thread_alt_stack_pointer <= thread_alt_stack_pointer + 32'h4;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ctrl_spsel <= 1'b0;
      handler_mode <= 1'b0;
    end else if (state == CRS_ST_SAVE && save_cnt == 4'h0) begin
      handler_mode <= 1'b1;
    end else if (running && evt.exc_exit && handler_mode) begin
      handler_mode <= !exit_to_thread;
      ctrl_spsel <= exit_to_thread && exit_alt;
    end else if (running && evt.ctrl_wr && in_thread) begin
      ctrl_spsel <= evt.ctrl_data[CRS_CTRL_SPSEL_BIT];
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      frame_alt <= 1'b0;
    end else if (running && next_state == CRS_ST_SAVE) begin
      frame_alt <= use_alt;
    end else if (running && next_state == CRS_ST_RESTORE) begin
      frame_alt <= exit_to_thread && exit_alt;
    end
  end

  // ----------------------------------------------------------------
  // Control sequence: vector fetch, run, save, restore, debug, core_stuck_flag
  // ----------------------------------------------------------------
  always_comb begin
    next_state = state;
    case (state)
      CRS_ST_RESET: next_state = CRS_ST_LOAD_SP;
      CRS_ST_LOAD_SP: if (hready) next_state = hresp ? CRS_ST_LOCK : CRS_ST_LOAD_PC;
      CRS_ST_LOAD_PC: if (hready) next_state = hresp ? CRS_ST_LOCK : CRS_ST_RUN;
      CRS_ST_RUN: begin
        if (!bus_idle) next_state = CRS_ST_RUN;
        else if (dbg_req_s) next_state = CRS_ST_HALT;
        else if (fault_in_handler && handler_mode) next_state = CRS_ST_LOCK;
        else if (irq_wins || evt.exc_enter) next_state = CRS_ST_SAVE;
        else if (evt.exc_exit && handler_mode) next_state = CRS_ST_RESTORE;
      end
      CRS_ST_SAVE: if (hready && save_cnt == 4'h7) next_state = CRS_ST_RUN;
      CRS_ST_RESTORE: if (hready && save_cnt == 4'h7) next_state = CRS_ST_RUN;
      CRS_ST_HALT: if (debug_resume) next_state = CRS_ST_RUN;
      CRS_ST_LOCK: next_state = CRS_ST_LOCK;
      default: next_state = CRS_ST_RESET;
    endcase
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state <= CRS_ST_RESET;
      save_cnt <= 4'h0;
      irq_pending <= 1'b0;
    end else begin
      state <= next_state;
      save_cnt <= (next_state != state) ? 4'h0 :
                  ((state == CRS_ST_SAVE || state == CRS_ST_RESTORE) && hready)
                  ? save_cnt + 4'h1 : save_cnt;
      // Arrival beats the clear of the pending flag
      irq_pending <= irq_in || (irq_pending && !(running && next_state == CRS_ST_SAVE));
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      program_counter <= CRS_ZERO;
    end else if (pc_load) begin
      program_counter <= hrdata & CRS_PC_MASK;
    end else if (running && evt.pc_wr) begin
      program_counter <= evt.pc_data & CRS_PC_MASK;
    end
  end

  // ----------------------------------------------------------------
  // Bus master and status outputs
  // ----------------------------------------------------------------
  // Pointer moves every beat, so the address needs no beat offset
  wire [31:0] frame_sp = frame_alt ? thread_alt_stack_pointer : primary_stack_pointer;
  wire [31:0] stack_addr = frame_sp - 32'h4;
  wire [31:0] pop_addr = frame_sp;
  wire [1:0] next_kind = (state == CRS_ST_LOAD_SP) ? BEAT_SP :
                         (state == CRS_ST_LOAD_PC) ? BEAT_PC :
                         (state == CRS_ST_RESTORE) ? BEAT_POP : BEAT_NONE;
  // Pops come back in reverse push order
  wire [3:0] next_pop_idx = 4'h7 - save_cnt;
  wire bus_active = state == CRS_ST_LOAD_SP || state == CRS_ST_LOAD_PC ||
                    state == CRS_ST_SAVE || state == CRS_ST_RESTORE;
  wire [31:0] next_haddr = (state == CRS_ST_LOAD_SP) ? CRS_VEC_SP_ADDR :
                           (state == CRS_ST_LOAD_PC) ? CRS_VEC_RESET_ADDR :
                           (state == CRS_ST_SAVE) ? stack_addr : pop_addr;
  wire [31:0] next_hwdata = (save_cnt < 4'(CRS_NUM_GPR)) ? gpr[save_cnt] : link_register;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      haddr <= CRS_ZERO;
      hwdata <= CRS_ZERO;
      htrans <= CRS_HTRANS_IDLE;
      hwrite <= 1'b0;
      push_data <= CRS_ZERO;
      a_kind <= BEAT_NONE;
      a_idx <= 4'h0;
      d_kind <= BEAT_NONE;
      d_idx <= 4'h0;
      rd_data <= CRS_ZERO;
      rd_refused <= 1'b0;
      sp_select <= 1'b0;
      irq_take <= 1'b0;
      regs_busy <= 1'b1;
      hresetn <= 1'b0;
      watchdog_timer_reset_out_n <= 1'b0;
      debug_halt_flag <= 1'b0;
      core_stuck_flag <= 1'b0;
    end else begin
      if (hready) begin
        haddr <= next_haddr;
        // Write data trails its address by one accepted beat
        push_data <= next_hwdata;
        hwdata <= push_data;
        a_kind <= next_kind;
        a_idx <= next_pop_idx;
        d_kind <= a_kind;
        d_idx <= a_idx;
        htrans <= bus_active ? CRS_HTRANS_NONSEQ : CRS_HTRANS_IDLE;
        hwrite <= state == CRS_ST_SAVE;
      end
      rd_data <= refuse_rd ? CRS_ZERO : rd_mux;
      rd_refused <= refuse_rd;
      sp_select <= use_alt;
      irq_take <= running && irq_wins;
      regs_busy <= !running;
      hresetn <= 1'b1;
      watchdog_timer_reset_out_n <= 1'b1;
      debug_halt_flag <= state == CRS_ST_HALT;
      core_stuck_flag <= state == CRS_ST_LOCK;
    end
  end

  assign hsize = CRS_HSIZE_WORD;
  assign hburst = CRS_HBURST_SINGLE;
  assign hprot = CRS_HPROT_DATA;
  assign hmastlock = 1'b0;
endmodule : crs_core_regs
`default_nettype wire

// [sim/crs_core_regs_props.sv]
// Concurrent checks on the ports of the core register set.
// Assumes one clock domain and the synchronous active-low reset rstn.
`timescale 1ns/1ps
`default_nettype none
module crs_core_regs_props
  import crs_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic fault_in_handler,
  input wire logic external_debug_request,
  input wire crs_req_t req,
  input wire crs_evt_t evt,
  input wire logic [31:0] rd_data,
  input wire logic rd_refused,
  input wire logic [31:0] program_counter,
  input wire logic handler_mode,
  input wire logic sp_select,
  input wire logic irq_take,
  input wire logic regs_busy,
  input wire logic hresetn,
  input wire logic debug_halt_flag,
  input wire logic core_stuck_flag,
  input wire logic hready,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans
);
  logic sel_bit;
  assign sel_bit = evt.ctrl_data[CRS_CTRL_SPSEL_BIT];
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);

  reset_state_a: assert property ($rose(rstn) |-> !sp_select && !handler_mode)
    else $error("mode or stack not cleared by reset");
  bus_reset_a: assert property ($rose(rstn) |-> !hresetn && htrans == CRS_HTRANS_IDLE)
    else $error("bus not held in reset");
  pc_align_a: assert property (!regs_busy |-> !program_counter[0])
    else $error("program counter bit zero set");
  handler_main_a: assert property (handler_mode && !regs_busy |-> !sp_select)
    else $error("handler not on main stack");
  ctrl_sel_a: assert property (!regs_busy && !handler_mode && evt.ctrl_wr && !evt.exc_enter
    |=> ##1 (regs_busy || sp_select == $past(sel_bit, 2))) else $error("control write lost");
  narrow_refuse_a: assert property (!regs_busy && req.narrow && req.rd_idx >= 4'h8
    |=> rd_refused && rd_data == CRS_ZERO) else $error("narrow high read not refused");
  sp_align_a: assert property (!regs_busy && !req.narrow && req.rd_idx == CRS_IDX_SP
    |=> rd_data[1:0] == 2'h0) else $error("stack pointer not word aligned");
  enter_a: assert property (!regs_busy && !handler_mode && evt.exc_enter
    |-> ##[1:80] handler_mode) else $error("exception entry too slow");
  stuck_a: assert property (!regs_busy && handler_mode && fault_in_handler
    |-> ##[1:8] core_stuck_flag) else $error("core_stuck_flag flag missing");
  halt_a: assert property (!regs_busy && external_debug_request |-> ##[1:8] debug_halt_flag)
    else $error("halt flag missing");
  ahb_hold_a: assert property (htrans != CRS_HTRANS_IDLE && !hready
    |=> $stable(haddr) && $stable(htrans)) else $error("address changed in wait state");

  c_irq: cover property (irq_take);
  c_alt: cover property ($rose(sp_select));
  c_lock: cover property ($rose(core_stuck_flag));
endmodule : crs_core_regs_props
bind crs_core_regs crs_core_regs_props props (.clk, .rstn, .fault_in_handler,
  .external_debug_request, .req, .evt, .rd_data, .rd_refused, .program_counter, .handler_mode,
  .sp_select, .irq_take, .regs_busy, .hresetn, .debug_halt_flag, .core_stuck_flag, .hready,
  .haddr, .htrans);
`default_nettype wire

// [sim/crs_ahb_slave.sv]
// Bus slave model: word memory holding the vector table, optional wait states.
// Assumes single word transfers; read data scrambles whenever not valid.
`timescale 1ns/1ps
`default_nettype none
module crs_ahb_slave #(
  parameter logic [31:0] SP0 = 32'h00000F00,
  parameter logic [31:0] PC0 = 32'h00000101
) (
  input wire logic clk,
  input wire logic hresetn,
  input wire logic slow,
  input wire logic [31:0] haddr,
  input wire logic [31:0] hwdata,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  output logic hready,
  output logic hresp,
  output logic [31:0] hrdata
);
  logic [31:0] mem [0:1023];
  logic [31:0] last = 32'h0;
  logic [9:0] a;
  logic act;
  logic wr;
  // Stale data flips each cycle so a late sample never matches
  assign hrdata = (act && !wr && hready) ? mem[a] : ~last;
  assign hresp = 1'b0;
  initial begin
    for (int i = 2; i < 1024; i++) mem[i] = 32'hA5000000 + i;
    mem[0] = SP0;
    mem[1] = PC0;
  end
  always @(posedge clk) begin
    last <= hrdata;
    if (!hresetn) begin
      act <= 1'b0;
      hready <= 1'b1;
    end else if (hready) begin
      if (act && wr) mem[a] <= hwdata;
      act <= htrans[1];
      wr <= hwrite;
      a <= haddr[11:2];
      hready <= !(htrans[1] && slow);
    end else begin
      hready <= 1'b1;
    end
  end
endmodule : crs_ahb_slave
`default_nettype wire

// [sim/test_core_register_set_stack_modes.sv]
// Bench for the core register set: registers, stacks, modes, resets.
// Assumes the slave model and the bound checker are compiled first.
`timescale 1ns/1ps
`default_nettype none
module test_core_register_set_stack_modes
  import crs_pkg::*;
();
  localparam logic [31:0] SP0 = 32'h00000F00;
  localparam logic [31:0] PC0 = 32'h00000101;
  logic clk = 0, rstn = 0, external_power_on_reset_n = 1, watchdog_reset_in = 0;
  logic external_debug_request = 0, debug_resume = 0, fault_in_handler = 0, irq_in = 0, slow = 0;
  logic [1:0] irq_prio = 2'h0, run_prio = 2'h3;
  crs_req_t req = '0;
  crs_evt_t evt = '0;
  logic [31:0] rd_data, program_counter, haddr, hwdata, hrdata, d, psp;
  logic rd_refused, handler_mode, sp_select, irq_take, regs_busy, hresetn;
  logic debug_halt_flag, core_stuck_flag, hready, hresp, hwrite, nb;
  logic [1:0] htrans;
  logic [3:0] ix, fl;
  logic [31:0] shadow [0:14];
  int fails = 0, n_checks = 0, seed = 32'h5d83;
  assign fl = {core_stuck_flag, debug_halt_flag, handler_mode, regs_busy};
  crs_core_regs uut (.clk, .rstn, .external_power_on_reset_n, .watchdog_reset_in,
    .external_debug_request, .debug_resume, .fault_in_handler, .irq_in, .irq_prio, .run_prio,
    .req, .evt, .rd_data, .rd_refused, .program_counter, .handler_mode, .sp_select, .irq_take,
    .regs_busy, .hresetn, .watchdog_timer_reset_out_n(), .debug_halt_flag, .core_stuck_flag,
    .hready, .hresp, .hrdata, .haddr, .hwdata, .htrans, .hwrite, .hsize(), .hburst(), .hprot(),
    .hmastlock());
  crs_ahb_slave #(.SP0(SP0), .PC0(PC0)) mem_model (.clk, .hresetn, .slow, .haddr, .hwdata,
    .htrans, .hwrite, .hready, .hresp, .hrdata);
  initial forever #10 clk = ~clk;
  initial begin
    #(20 * 20000);
    fails++;
    conclude();
  end
  function automatic logic refused(logic [3:0] i, logic n);
    return n && i >= 4'h8;
  endfunction : refused
  function automatic logic [31:0] wv(logic [3:0] i, logic [31:0] v);
    return (i == CRS_IDX_SP) ? (v & CRS_SP_MASK) : v;
  endfunction : wv
  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      fails++;
      $display("unexpected %s: expected %h, seen %h", nm, e, g);
    end
  endtask : chk
  task automatic tick(int n = 1);
    repeat (n) @(negedge clk);
  endtask : tick
  // Leaves the write strobe up; the next read or event lowers it
  task automatic wr(logic [3:0] i, logic [31:0] v, logic n);
    req.wr_en = 1'b1;
    req.wr_idx = i;
    req.wr_data = v;
    req.narrow = n;
    tick();
  endtask : wr
  task automatic rd(string nm, logic [3:0] i, logic n, logic [31:0] e);
    req.wr_en = 1'b0;
    req.rd_idx = i;
    req.narrow = n;
    tick();
    chk(nm, refused(i, n) ? CRS_ZERO : e, rd_data);
    chk("rd_refused", {31'h0, refused(i, n)}, {31'h0, rd_refused});
  endtask : rd
  task automatic ev(crs_evt_t e);
    req.wr_en = 1'b0;
    evt = e;
    tick();
    evt = '0;
    tick();
  endtask : ev
  task automatic wait_for(string nm, int k, logic v);
    int n;
    n = 0;
    while (fl[k] !== v && n < 400) begin
      tick();
      n++;
    end
    chk(nm, {31'h0, v}, {31'h0, fl[k]});
  endtask : wait_for
  task automatic conclude();
    $display("checks %0d, mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : conclude
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    tick(8);
    rstn = 1'b1;
    wait_for("regs_busy", 0, 0);
    rd("sp_vector", CRS_IDX_SP, 1'b0, SP0);
    chk("pc_bit0", 0, {31'h0, program_counter[0]});
    for (int i = 0; i < 15; i++) begin
      d = $random(seed);
      shadow[i] = wv(i[3:0], d);
      wr(i[3:0], d, 1'b0);
    end
    for (int k = 0; k < 60; k++) begin
      d = $random(seed);
      ix = 4'(($random(seed) & 32'hFF) % 15);
      nb = d[7];
      wr(ix, d, nb);
      if (!refused(ix, nb)) shadow[ix] = wv(ix, d);
      ix = 4'(d[15:8] % 15);
      rd("reg", ix, d[3], shadow[ix]);
    end
    rd("low_narrow", 4'h7, 1'b1, shadow[7]);
    rd("high_narrow", 4'h8, 1'b1, shadow[8]);
    psp = 32'h00000800;
    wr(CRS_IDX_SP, 32'h00000C03, 1'b0);
    shadow[13] = 32'h00000C00;
    ev('{ctrl_wr: 1'b1, ctrl_data: 32'h2, default: 0});
    chk("sp_select", 1, {31'h0, sp_select});
    wr(CRS_IDX_SP, psp | 32'h1, 1'b0);
    rd("alt_sp", CRS_IDX_SP, 1'b0, psp);
    for (int s = 0; s < 2; s++) begin
      slow = s[0];
      ev('{ctrl_wr: 1'b1, ctrl_data: {30'h0, s[0], 1'b0}, default: 0});
      rd("pre_sp", CRS_IDX_SP, 1'b0, s ? psp : shadow[13]);
      // One-cycle pulse: a held level would be pended again and taken twice
      if (s == 1) begin
        irq_in = 1'b1;
        tick();
        irq_in = 1'b0;
      end else begin
        ev('{exc_enter: 1'b1, default: 0});
      end
      wait_for("handler_mode", 1, 1);
      irq_in = 1'b0;
      wait_for("regs_busy", 0, 0);
      chk("handler_sp", 0, {31'h0, sp_select});
      rd("frame_sp", CRS_IDX_SP, 1'b0, s ? shadow[13] : shadow[13] - 32'h20);
      rd("lr_code", CRS_IDX_LR, 1'b0, 32'hFFFFFFF9 | {29'h0, s[0], 2'h0});
      ev('{ctrl_wr: 1'b1, ctrl_data: 32'h2, default: 0});
      chk("handler_sp", 0, {31'h0, sp_select});
      wr(4'h0, ~shadow[0], 1'b0);
      ev('{exc_exit: 1'b1, exit_code: 32'hFFFFFFF9 | {29'h0, s[0], 2'h0}, default: 0});
      wait_for("handler_mode", 1, 0);
      wait_for("regs_busy", 0, 0);
      chk("thread_sp", s, {31'h0, sp_select});
      rd("r0_restored", 4'h0, 1'b0, shadow[0]);
      rd("post_sp", CRS_IDX_SP, 1'b0, s ? psp : shadow[13]);
    end
    external_debug_request = 1'b1;
    wait_for("halt", 2, 1);
    external_debug_request = 1'b0;
    wr(4'h1, ~shadow[1], 1'b0);
    req.wr_en = 1'b0;
    debug_resume = 1'b1;
    tick();
    debug_resume = 1'b0;
    wait_for("halt", 2, 0);
    wait_for("regs_busy", 0, 0);
    rd("debug_halt_flag_write", 4'h1, 1'b0, shadow[1]);
    ev('{exc_enter: 1'b1, default: 0});
    wait_for("regs_busy", 0, 0);
    fault_in_handler = 1'b1;
    wait_for("core_stuck_flag", 3, 1);
    fault_in_handler = 1'b0;
    for (int r = 0; r < 3; r++) begin
      rstn = (r != 0);
      external_power_on_reset_n = (r != 1);
      watchdog_reset_in = (r == 2);
      tick(4);
      chk("hresetn", 0, {31'h0, hresetn});
      rstn = 1'b1;
      external_power_on_reset_n = 1'b1;
      watchdog_reset_in = 1'b0;
      wait_for("regs_busy", 0, 0);
      chk("reset_mode", 0, {29'h0, core_stuck_flag, handler_mode, sp_select});
      rd("sp_vector", CRS_IDX_SP, 1'b0, SP0);
      rd("kept", 4'h1, 1'b0, shadow[1]);
    end
    conclude();
  end
endmodule : test_core_register_set_stack_modes
`default_nettype wire
